//--- verification/charger_checks_asserts.sv
// Purpose: port-level assertions for the charger mode select and timers
// Assumes: single sys_clk domain, reset asynchronous active high
// Notes: the precharge bound is built from the slow tick divider
module charger_checks
    import charger_ctrl_pkg::*;
#(
    parameter logic [TIMER_W-1:0] PRECHARGE_TICKS = 15
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic input_ready,
    input wire logic mode_strap_pin,
    input wire logic [2:0] strap_voltage_code,
    input wire logic [3:0] current_set_code,
    input wire logic [2:0] host_voltage_code,
    input wire logic [3:0] host_current_code,
    input wire logic termination_reached,
    input wire logic mode_valid,
    input wire logic host_mode,
    input wire logic [2:0] charge_voltage_target,
    input wire logic [3:0] fast_charge_current,
    input wire logic charging,
    input wire logic precharge_active,
    input wire logic charge_done,
    input wire logic precharge_timeout,
    input wire logic safety_timeout,
    input wire logic watchdog_expired
);
    timeunit 1ns;
    timeprecision 1ns;
    // wide enough for the full-length precharge count
    localparam longint PRE_MAX = longint'(PRECHARGE_TICKS) * longint'(SLOW_DIV) + 8;
    int pre_run;

    // cycles spent in precharge; a stuck timer lets this run past the bound
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pre_run <= 0;
        end else begin
            pre_run <= precharge_active ? pre_run + 1 : 0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_mode_after_start: assert property ($rose(mode_valid) |-> $past(input_ready, 2))
        else $error("mode valid without settled start-up");
    a_mode_from_strap: assert property ($rose(mode_valid) |-> host_mode == $past(mode_strap_pin))
        else $error("mode differs from sampled strap");
    a_host_params: assert property (mode_valid && $past(mode_valid) && host_mode |->
        charge_voltage_target == $past(host_voltage_code)
        && fast_charge_current == $past(host_current_code)) else $error("host params not applied");
    a_strap_params: assert property (mode_valid && $past(mode_valid) && !host_mode |->
        charge_voltage_target == $past(strap_voltage_code)
        && fast_charge_current == $past(current_set_code)) else $error("strap params not applied");
    a_params_idle: assert property (!mode_valid |-> !charge_voltage_target && !fast_charge_current)
        else $error("params applied before mode known");
    a_mode_kept: assert property (mode_valid && $past(mode_valid) |-> $stable(host_mode))
        else $error("mode changed after sampling");
    a_mode_drop: assert property (!input_ready |=> !mode_valid)
        else $error("mode kept without input");
    a_precharge_bound: assert property (pre_run <= PRE_MAX)
        else $error("precharge outlived its timer");
    a_precharge_stop: assert property ($rose(precharge_timeout) |-> ##[0:2] !charging)
        else $error("charging went on after precharge timeout");
    a_safety_stop: assert property ($rose(safety_timeout) |-> ##[0:2] !charging)
        else $error("charging went on after safety timeout");
    a_done_cause: assert property ($rose(charge_done) |-> $past(termination_reached))
        else $error("done without termination");
    a_wd_host_only: assert property ($rose(watchdog_expired) |-> mode_valid && host_mode)
        else $error("watchdog expired outside host mode");
endmodule : charger_checks

bind charger_mode_select_timers charger_checks #(.PRECHARGE_TICKS(PRECHARGE_TICKS)) chk (
    .sys_clk, .reset, .input_ready, .mode_strap_pin, .strap_voltage_code, .current_set_code,
    .host_voltage_code, .host_current_code, .termination_reached, .mode_valid, .host_mode,
    .charge_voltage_target, .fast_charge_current, .charging, .precharge_active, .charge_done,
    .precharge_timeout, .safety_timeout, .watchdog_expired
);

//--- verification/charger_mode_select_timers_test.sv
// Purpose: self-checking bench for mode select, parameter routing and timers
// Assumes: shortened tick counts, slow tick every SLOW_DIV clocks
// Notes: timer spans are judged against a one-tick window
module charger_mode_select_timers_test
    import charger_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = int'(SLOW_DIV);
    localparam int WD = 20;
    localparam int SF = 50;
    localparam int PR = 15;
    logic sys_clk = 0, reset = 1, input_ready = 0, mode_strap_pin = 0;
    logic [2:0] strap_voltage_code = 0, wr_volt = 0;
    logic [3:0] current_set_code = 0, wr_curr = 0;
    logic [7:0] wr_tctl = 0;
    logic charge_enable = 0, below_precharge = 0, termination_reached = 0, wr = 0, kick_on = 0;
    logic [2:0] host_voltage_code, charge_voltage_target;
    logic [3:0] host_current_code, fast_charge_current, flags;
    logic [7:0] timer_control;
    logic watchdog_kick, mode_valid, host_mode, charging, precharge_active, charge_done;
    logic precharge_timeout, safety_timeout, watchdog_expired;
    int fail_count = 0, checks = 0;
    int unsigned seed = 2769;

    assign flags = {watchdog_expired, safety_timeout, precharge_timeout, charge_done};

    host_ctrl_model host (.sys_clk, .reset, .wr, .wr_volt, .wr_curr, .wr_tctl, .kick_on,
        .host_voltage_code, .host_current_code, .timer_control, .watchdog_kick);

    charger_mode_select_timers #(.WATCHDOG_TICKS(WD), .WATCHDOG_B_TICKS(30), .WATCHDOG_C_TICKS(40),
        .SAFETY_TICKS(SF), .SAFETY_A_TICKS(10), .SAFETY_B_TICKS(25), .PRECHARGE_TICKS(PR)) dut (
        .sys_clk, .reset, .input_ready, .mode_strap_pin, .strap_voltage_code, .current_set_code,
        .host_voltage_code, .host_current_code, .timer_control, .watchdog_kick, .charge_enable,
        .below_precharge, .termination_reached, .mode_valid, .host_mode, .charge_voltage_target,
        .fast_charge_current, .charging, .precharge_active, .charge_done, .precharge_timeout,
        .safety_timeout, .watchdog_expired);

    // free-running system clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // true when a timer span falls inside one slow tick of its terminal count
    function automatic logic in_span(int n, int ticks);
        return n >= (ticks - 1) * DIV && n <= ticks * DIV + 8;
    endfunction : in_span

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        checks++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : step

    task automatic host_write(input logic [2:0] v, input logic [3:0] c, input logic [7:0] t);
        @(posedge sys_clk);
        wr <= 1'b1;
        wr_volt <= v;
        wr_curr <= c;
        wr_tctl <= t;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : host_write

    // drop the input, then bring it up with the strap at the wanted level
    task automatic start_up(input logic strap);
        @(posedge sys_clk);
        input_ready <= 1'b0;
        charge_enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        mode_strap_pin <= strap;
        input_ready <= 1'b1;
        step(4);
    endtask : start_up

    task automatic wait_flag(input int b, input int max, output int n);
        n = 0;
        while (flags[b] !== 1'b1 && n < max) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_flag

    task automatic summarize();
        $display("checks %0d failures %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    initial begin
        int n;
        logic h;
        logic [2:0] v;
        logic [3:0] c;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        // both strap levels with random codes, then strap and strap voltage code moved after sampling
        for (int i = 0; i < 6; i++) begin
            h = i[0];
            v = 3'(rnd());
            c = 4'(rnd());
            host_write(v, c, 8'h00);
            strap_voltage_code <= ~v;
            current_set_code <= ~c;
            start_up(h);
            check(host_mode, h, "mode pick");
            check(mode_valid, 1'b1, "mode valid");
            check(charge_voltage_target, h ? v : 3'(~v), "voltage source");
            check(fast_charge_current, h ? c : 4'(~c), "current source");
            @(posedge sys_clk);
            mode_strap_pin <= ~h;
            strap_voltage_code <= v ^ 3'h5;
            step(3);
            check(host_mode, h, "late strap ignored");
            check(charge_voltage_target, h ? v : v ^ 3'h5, "params tracked");
        end
        $display("test mode select done");
        // precharge never passes: timeout, then enable toggling refused
        start_up(1'b1);
        @(posedge sys_clk);
        charge_enable <= 1'b1;
        below_precharge <= 1'b1;
        step(3);
        check(precharge_active, 1'b1, "precharge entered");
        wait_flag(1, PR * DIV + 200, n);
        check(in_span(n, PR), 1'b1, "precharge span");
        step(3);
        check(charging, 1'b0, "cycle ended");
        @(posedge sys_clk);
        charge_enable <= 1'b0;
        step(2);
        @(posedge sys_clk);
        charge_enable <= 1'b1;
        step(3);
        check(charging, 1'b0, "fault holds");
        $display("test precharge timeout done");
        // fast charge without termination under the 20 h code
        host_write(3'h2, 4'h3, 8'h06);
        start_up(1'b1);
        @(posedge sys_clk);
        below_precharge <= 1'b0;
        charge_enable <= 1'b1;
        wait_flag(2, SF * DIV + 200, n);
        check(in_span(n, SF), 1'b1, "safety span");
        step(3);
        check(charging, 1'b0, "safety stop");
        // the two shorter safety codes
        for (int k = 1; k < 3; k++) begin
            host_write(3'h2, 4'h3, 8'(k << 1));
            start_up(1'b1);
            @(posedge sys_clk);
            charge_enable <= 1'b1;
            wait_flag(2, 25 * DIV + 200, n);
            check(in_span(n, k == 1 ? 10 : 25), 1'b1, "safety code span");
        end
        $display("test safety timeout done");
        // normal cycle through both phases to done
        start_up(1'b0);
        @(posedge sys_clk);
        charge_enable <= 1'b1;
        below_precharge <= 1'b1;
        step(3);
        check(precharge_active, 1'b1, "precharge phase");
        @(posedge sys_clk);
        below_precharge <= 1'b0;
        step(3);
        check({charging, precharge_active}, 2'b10, "fast phase");
        @(posedge sys_clk);
        termination_reached <= 1'b1;
        step(3);
        check({charge_done, charging, safety_timeout}, 3'b100, "done");
        @(posedge sys_clk);
        termination_reached <= 1'b0;
        $display("test charge cycle done");
        // watchdog at 40 s code: unkicked, kicked, then standalone
        host_write(3'h1, 4'h1, 8'h10);
        start_up(1'b1);
        wait_flag(3, WD * DIV + 200, n);
        check(in_span(n, WD), 1'b1, "watchdog span");
        kick_on <= 1'b1;
        step(1000);
        check(watchdog_expired, 1'b0, "one kick clears");
        step(5000);
        check(watchdog_expired, 1'b0, "kicks hold it off");
        // the other period codes, each flag cleared by kicks afterwards
        for (int k = 2; k < 4; k++) begin
            kick_on <= 1'b0;
            host_write(3'h1, 4'h1, 8'(k << 4));
            start_up(1'b1);
            wait_flag(3, 40 * DIV + 200, n);
            check(in_span(n, k * 10 + 10), 1'b1, "watchdog code span");
            kick_on <= 1'b1;
            step(1000);
        end
        kick_on <= 1'b0;
        start_up(1'b0);
        step(5000);
        check(watchdog_expired, 1'b0, "no watchdog standalone");
        $display("test watchdog done");
        summarize();
    end

    // cut a hang short well past the expected run length
    initial begin
        #3200000;
        fail_count++;
        $display("CHECK FAILED %0t run timed out", $time);
        summarize();
    end
endmodule : charger_mode_select_timers_test

//--- verification/host_ctrl_model.sv
// Purpose: behavioural host that owns the charge and timer registers
// Assumes: writes arrive as one-cycle strobes from the bench
// Notes: kicks every 950 clocks, well inside the shortened watchdog
module host_ctrl_model
    import charger_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr,
    input wire logic [2:0] wr_volt,
    input wire logic [3:0] wr_curr,
    input wire logic [7:0] wr_tctl,
    input wire logic kick_on,
    output logic [2:0] host_voltage_code,
    output logic [3:0] host_current_code,
    output logic [7:0] timer_control,
    output logic watchdog_kick
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap;

    // a write lands one edge after its strobe, like a completed bus write
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            host_voltage_code <= VOLT_RESET;
            host_current_code <= CURR_RESET;
            timer_control <= 8'h00;
            watchdog_kick <= 1'b0;
            gap <= 0;
        end else begin
            if (wr) begin
                host_voltage_code <= wr_volt;
                host_current_code <= wr_curr;
                timer_control <= wr_tctl;
            end
            gap <= (gap == 949) ? 0 : gap + 1;
            watchdog_kick <= kick_on && gap == 0;
        end
    end
endmodule : host_ctrl_model

//--- verilog/charger_ctrl_pkg.sv
// Purpose: shared constants for the charger mode select and timer logic
// Assumes: 25 MHz system clock, slow timebase derived at 131 kHz
// Notes: durations are kept in their own units, tick counts derived from them
package charger_ctrl_pkg;

    // clock rates
    localparam longint unsigned SYS_CLK_HZ = 64'd25_000_000;
    localparam longint unsigned SLOW_CLK_HZ = 64'd131_000;
    // system clocks per slow tick, rounded down so the tick never runs slow
    localparam logic [7:0] SLOW_DIV = 8'(SYS_CLK_HZ / SLOW_CLK_HZ);

    // timer widths
    localparam int TIMER_W = 34;

    // durations in their printed units
    localparam longint unsigned WATCHDOG_SEC = 64'd40;
    localparam longint unsigned SAFETY_NOM_HOURS = 64'd20;
    localparam longint unsigned SAFETY_MIN_HOURS = 64'd16;
    localparam longint unsigned PRECHARGE_MIN = 64'd60;

    // durations as slow ticks
    localparam longint unsigned WATCHDOG_TICKS_DEF = WATCHDOG_SEC * SLOW_CLK_HZ;
    localparam longint unsigned SAFETY_TICKS_DEF = SAFETY_NOM_HOURS * 64'd3600 * SLOW_CLK_HZ;
    localparam longint unsigned SAFETY_MIN_TICKS = SAFETY_MIN_HOURS * 64'd3600 * SLOW_CLK_HZ;
    localparam longint unsigned PRECHARGE_TICKS_DEF = PRECHARGE_MIN * 64'd60 * SLOW_CLK_HZ;

    // timer control word layout
    localparam int WD_FIELD_LO = 4;
    localparam int SAFETY_FIELD_LO = 1;
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic [1:0] WD_SEL_40S = 2'h1;
    localparam logic [1:0] WD_SEL_B = 2'h2;
    localparam logic [1:0] WD_SEL_C = 2'h3;
    localparam logic [1:0] SAFETY_SEL_A = 2'h1;
    localparam logic [1:0] SAFETY_SEL_B = 2'h2;
    localparam logic [1:0] SAFETY_SEL_20H = 2'h3;

    // reset values
    localparam logic [2:0] VOLT_RESET = 3'h0;
    localparam logic [3:0] CURR_RESET = 4'h0;

    typedef enum {
        ST_WAIT_INPUT,
        ST_SAMPLE,
        ST_IDLE,
        ST_PRECHARGE,
        ST_FAST,
        ST_DONE,
        ST_FAULT
    } charge_state_e;

endpackage : charger_ctrl_pkg

//--- verilog/charger_mode_select_timers.sv
// Purpose: mode strap sampling, charge parameter selection and charge timers
// Assumes: all inputs synchronous to sys_clk; analog codes settle before input_ready
// Notes: timers run from a slow tick derived from sys_clk
//
// Contract
// [R1] after input start-up, sample mode strap before applying charge parameters
// [R2] strap high selects host-control mode
// [R3] strap grounded through resistor selects standalone mode
// [R4] host-control mode takes voltage and current from host-written registers
// [R5] standalone mode takes voltage and current from strap and current-set resistors
// [R6] watchdog field bits 5:4 equal 01 gives 40 second watchdog
// [R7] safety field bits 2:1 equal 11 gives 20 hour safety timer
// [R8] precharge not passed within 60 minutes ends cycle with timeout fault
// [R9] termination not reached before safety expiry stops cycle with timeout fault
// [R10] all timers are counters of the slow oscillator tick
module charger_mode_select_timers
    import charger_ctrl_pkg::*;
#(
    parameter logic [TIMER_W-1:0] WATCHDOG_TICKS = TIMER_W'(WATCHDOG_TICKS_DEF),
    parameter logic [TIMER_W-1:0] WATCHDOG_B_TICKS = TIMER_W'(2 * WATCHDOG_TICKS_DEF),
    parameter logic [TIMER_W-1:0] WATCHDOG_C_TICKS = TIMER_W'(4 * WATCHDOG_TICKS_DEF),
    parameter logic [TIMER_W-1:0] SAFETY_TICKS = TIMER_W'(SAFETY_TICKS_DEF),
    parameter logic [TIMER_W-1:0] SAFETY_A_TICKS = TIMER_W'(SAFETY_TICKS_DEF / 4),
    parameter logic [TIMER_W-1:0] SAFETY_B_TICKS = TIMER_W'(SAFETY_TICKS_DEF / 2),
    parameter logic [TIMER_W-1:0] PRECHARGE_TICKS = TIMER_W'(PRECHARGE_TICKS_DEF)
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic input_ready,
    input wire logic mode_strap_pin,
    input wire logic [2:0] strap_voltage_code,
    input wire logic [3:0] current_set_code,
    input wire logic [2:0] host_voltage_code,
    input wire logic [3:0] host_current_code,
    input wire logic [7:0] timer_control,
    input wire logic watchdog_kick,
    input wire logic charge_enable,
    input wire logic below_precharge,
    input wire logic termination_reached,
    output logic mode_valid,
    output logic host_mode,
    output logic [2:0] charge_voltage_target,
    output logic [3:0] fast_charge_current,
    output logic charging,
    output logic precharge_active,
    output logic charge_done,
    output logic precharge_timeout,
    output logic safety_timeout,
    output logic watchdog_expired
);

    // watchdog period from its two-bit field
    function automatic logic [TIMER_W-1:0] watchdog_limit(input logic [1:0] sel);
        case (sel)
            WD_SEL_40S: watchdog_limit = WATCHDOG_TICKS; // R6
            WD_SEL_B: watchdog_limit = WATCHDOG_B_TICKS;
            WD_SEL_C: watchdog_limit = WATCHDOG_C_TICKS;
            default: watchdog_limit = '0;
        endcase
    endfunction : watchdog_limit

    // safety duration from its two-bit field
    function automatic logic [TIMER_W-1:0] safety_limit(input logic [1:0] sel);
        case (sel)
            SAFETY_SEL_20H: safety_limit = SAFETY_TICKS; // R7
            SAFETY_SEL_A: safety_limit = SAFETY_A_TICKS;
            SAFETY_SEL_B: safety_limit = SAFETY_B_TICKS;
            default: safety_limit = '0;
        endcase
    endfunction : safety_limit

    charge_state_e state;
    charge_state_e next_state;
    logic [7:0] div_count;
    logic [7:0] next_div_count;
    logic slow_tick;
    logic next_slow_tick;
    logic next_mode_valid;
    logic next_host_mode;
    logic [2:0] next_charge_voltage_target;
    logic [3:0] next_fast_charge_current;
    logic next_charging;
    logic next_precharge_active;
    logic next_charge_done;
    logic next_precharge_timeout;
    logic next_safety_timeout;
    logic next_watchdog_expired;
    logic pre_expired;
    logic safety_expired;
    logic wd_expired;
    logic wd_expired_prev;
    logic next_wd_expired_prev;
    logic in_cycle;

    // slow timebase: one tick per slow oscillator period
    always_comb begin
        next_div_count = div_count + 8'h01;
        next_slow_tick = 1'b0;
        if (div_count >= SLOW_DIV - 8'h01) begin
            next_div_count = 8'h00;
            next_slow_tick = 1'b1; // R10
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_count <= 8'h00;
            slow_tick <= 1'b0;
        end else begin
            div_count <= next_div_count;
            slow_tick <= next_slow_tick;
        end
    end

    assign in_cycle = (state == ST_PRECHARGE) || (state == ST_FAST);

    // precharge timer only runs while below the precharge threshold
    slow_timer #(
        .W(TIMER_W)
    ) u_pre_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(slow_tick),
        .run(state == ST_PRECHARGE),
        .clear(1'b0),
        .limit(PRECHARGE_TICKS),
        .expired(pre_expired)
    ); // R8 R10

    // safety timer spans the whole charge cycle
    slow_timer #(
        .W(TIMER_W)
    ) u_safety_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(slow_tick),
        .run(in_cycle),
        .clear(1'b0),
        .limit(safety_limit(timer_control[SAFETY_FIELD_LO +: 2])),
        .expired(safety_expired)
    ); // R9 R10

    // watchdog only matters when a host is present
    slow_timer #(
        .W(TIMER_W)
    ) u_watchdog_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(slow_tick),
        .run(mode_valid && host_mode),
        .clear(watchdog_kick),
        .limit(watchdog_limit(timer_control[WD_FIELD_LO +: 2])),
        .expired(wd_expired)
    ); // R6 R10

    // mode sampling, parameter selection and charge cycle sequencing
    always_comb begin
        next_state = state;
        next_mode_valid = mode_valid;
        next_host_mode = host_mode;
        next_charge_voltage_target = charge_voltage_target;
        next_fast_charge_current = fast_charge_current;
        next_precharge_timeout = precharge_timeout;
        next_safety_timeout = safety_timeout;
        // set on the expiry edge only, so a later kick clears it; a kick in that cycle loses
        next_wd_expired_prev = wd_expired;
        next_watchdog_expired = (wd_expired && !wd_expired_prev)
            || (watchdog_expired && !watchdog_kick);
        case (state)
            ST_WAIT_INPUT: begin
                next_mode_valid = 1'b0;
                if (input_ready) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // strap caught once per start-up, never during reset
                next_host_mode = mode_strap_pin; // R1 R2 R3
                next_mode_valid = 1'b1; // R1
                next_precharge_timeout = 1'b0;
                next_safety_timeout = 1'b0;
                next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (charge_enable) begin
                    next_state = below_precharge ? ST_PRECHARGE : ST_FAST;
                end
            end
            ST_PRECHARGE: begin
                if (pre_expired) begin
                    next_precharge_timeout = 1'b1; // R8
                    next_state = ST_FAULT;
                end else if (safety_expired) begin
                    next_safety_timeout = 1'b1; // R9
                    next_state = ST_FAULT;
                end else if (!charge_enable) begin
                    next_state = ST_IDLE;
                end else if (!below_precharge) begin
                    next_state = ST_FAST;
                end
            end
            ST_FAST: begin
                if (termination_reached) begin
                    next_state = ST_DONE;
                end else if (safety_expired) begin
                    next_safety_timeout = 1'b1; // R9
                    next_state = ST_FAULT;
                end else if (!charge_enable) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DONE: begin
                // a new cycle needs the enable to go away first
                if (!charge_enable) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FAULT: begin
                // a timeout fault clears only with a fresh input start-up
                next_state = ST_FAULT;
            end
            default: begin
                next_state = ST_WAIT_INPUT;
            end
        endcase
        // losing the input restarts everything but the watchdog_expired flag from mode sampling
        if (!input_ready) begin
            next_state = ST_WAIT_INPUT;
            next_mode_valid = 1'b0;
        end
        // parameters follow their source only once the mode is known
        if (next_mode_valid) begin
            if (next_host_mode) begin
                next_charge_voltage_target = host_voltage_code; // R4
                next_fast_charge_current = host_current_code; // R4
            end else begin
                next_charge_voltage_target = strap_voltage_code; // R5
                next_fast_charge_current = current_set_code; // R5
            end
        end else begin
            next_charge_voltage_target = VOLT_RESET;
            next_fast_charge_current = CURR_RESET;
        end
        next_charging = (next_state == ST_PRECHARGE) || (next_state == ST_FAST);
        next_precharge_active = next_state == ST_PRECHARGE;
        next_charge_done = next_state == ST_DONE;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= ST_WAIT_INPUT;
            mode_valid <= 1'b0;
            host_mode <= 1'b0;
            charge_voltage_target <= VOLT_RESET;
            fast_charge_current <= CURR_RESET;
            charging <= 1'b0;
            precharge_active <= 1'b0;
            charge_done <= 1'b0;
            precharge_timeout <= 1'b0;
            safety_timeout <= 1'b0;
            watchdog_expired <= 1'b0;
            wd_expired_prev <= 1'b0;
        end else begin
            state <= next_state;
            mode_valid <= next_mode_valid;
            host_mode <= next_host_mode;
            charge_voltage_target <= next_charge_voltage_target;
            fast_charge_current <= next_fast_charge_current;
            charging <= next_charging;
            precharge_active <= next_precharge_active;
            charge_done <= next_charge_done;
            precharge_timeout <= next_precharge_timeout;
            safety_timeout <= next_safety_timeout;
            watchdog_expired <= next_watchdog_expired;
            wd_expired_prev <= next_wd_expired_prev;
        end
    end

endmodule : charger_mode_select_timers

//--- verilog/slow_timer.sv
// Purpose: one timeout counter advanced by the slow timebase tick
// Assumes: tick is a one-cycle pulse, limit of zero means disabled
// Notes: expired holds until clear or run drops
module slow_timer
    import charger_ctrl_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    input wire logic [W-1:0] limit,
    output logic expired
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_expired;

    // count slow ticks while running, stop at the limit
    always_comb begin
        next_count = count;
        next_expired = expired;
        if (clear || !run) begin
            next_count = '0;
            next_expired = 1'b0;
        end else if (tick && !expired && limit != '0) begin
            next_count = count + W'(1);
            if (next_count >= limit) begin
                next_expired = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end

endmodule : slow_timer
